// ===== rtl/xid_pkg.sv
/*
 * Shared constants, timing tables and carrier types for the extended
 * instruction decode and cycle-timing block.
 * Assumes: a 16-bit core with a 20-bit program counter and 16 registers,
 * where register 0 is the program counter and register 1 the stack pointer.
 */
package xid_pkg;
    localparam int CYC_W = 6;
    localparam int LEN_W = 3;
    localparam int PC_W = 20;

    localparam logic [3:0] PC_REG = 4'h0;
    localparam logic [3:0] SP_REG = 4'h1;
    localparam logic [3:0] SR_REG = 4'h2;
    localparam logic [3:0] CG_REG = 4'h3;

    // Opcode map prefixes
    localparam logic [3:0] GRP_ADDR = 4'h0;
    localparam logic [7:0] CALL_PREFIX = 8'h13;
    localparam logic [15:0] RETURN_FROM_INTERRUPT_WORD = 16'h1300;
    localparam logic [5:0] MPP_PREFIX = 6'h05;
    localparam logic [5:0] FMT2_PREFIX = 6'h04;
    localparam logic [4:0] EXT_PREFIX = 5'h03;

    // Double-operand opcodes that get cycle reductions
    localparam logic [3:0] OPC_TRANSFER = 4'h4;
    localparam logic [3:0] OPC_SUM = 4'h5;
    localparam logic [3:0] OPC_MINUS = 4'h8;
    localparam logic [3:0] OPC_COMPARE = 4'h9;
    localparam logic [3:0] OPC_TEST = 4'hB;

    // Single-operand opcodes (bits 9:7); 0..3 share the rotate timing
    localparam logic [2:0] F2_ROT_LAST = 3'h3;
    localparam logic [2:0] F2_PUSH = 3'h4;

    // Address- and call-group identifiers in bits 7:4
    localparam logic [3:0] AID_ROT20 = 4'h4;
    localparam logic [3:0] AID_ROT16 = 4'h5;
    localparam logic [3:0] AID_IMM_MOVE = 4'h8;
    localparam logic [1:0] AID_REGREG = 2'h3;
    localparam logic [3:0] CID_IDX = 4'h5;
    localparam logic [3:0] CID_RSVD = 4'hA;
    localparam logic [3:0] CID_FIRST = 4'h4;

    localparam logic [CYC_W-1:0] CYC_ONE = 6'h01;
    localparam logic [CYC_W-1:0] CYC_TWO = 6'h02;
    localparam logic [CYC_W-1:0] RETURN_FROM_INTERRUPT_CYC = 6'h05;
    localparam logic [CYC_W-1:0] MPP_BASE = 6'h02;

    localparam logic [CYC_W-1:0] ADDR_CYC [0:15] = '{6'h03, 6'h03, 6'h04,
        6'h04, 6'h00, 6'h00, 6'h04, 6'h04, 6'h02, 6'h03, 6'h03, 6'h03,
        6'h01, 6'h01, 6'h01, 6'h01};
    localparam logic [LEN_W-1:0] ADDR_LEN [0:15] = '{3'h1, 3'h1, 3'h2,
        3'h2, 3'h0, 3'h0, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2,
        3'h1, 3'h1, 3'h1, 3'h1};
    localparam logic [CYC_W-1:0] CALL_CYC [0:15] = '{6'h00, 6'h00, 6'h00,
        6'h00, 6'h04, 6'h06, 6'h05, 6'h05, 6'h06, 6'h06, 6'h00, 6'h04,
        6'h00, 6'h00, 6'h00, 6'h00};
    localparam logic [LEN_W-1:0] CALL_LEN [0:15] = '{3'h0, 3'h0, 3'h0,
        3'h0, 3'h1, 3'h2, 3'h1, 3'h1, 3'h2, 3'h2, 3'h0, 3'h2,
        3'h0, 3'h0, 3'h0, 3'h0};

    // Double-operand tables: [source class][destination class]
    localparam logic [2:0] SRC_REG = 3'h0;
    localparam logic [2:0] SRC_IND = 3'h1;
    localparam logic [2:0] SRC_AUTO = 3'h2;
    localparam logic [2:0] SRC_IMM = 3'h3;
    localparam logic [2:0] SRC_MEM = 3'h4;
    localparam logic [1:0] DST_REG = 2'h0;
    localparam logic [1:0] DST_PC = 2'h1;
    localparam logic [1:0] DST_MEM = 2'h2;
    localparam logic [CYC_W-1:0] F1_CYC_BW [0:4][0:2] = '{
        '{6'h02, 6'h03, 6'h05}, '{6'h03, 6'h03, 6'h06},
        '{6'h03, 6'h04, 6'h06}, '{6'h03, 6'h04, 6'h06},
        '{6'h04, 6'h05, 6'h07}};
    localparam logic [CYC_W-1:0] F1_CYC_A [0:4][0:2] = '{
        '{6'h02, 6'h03, 6'h07}, '{6'h04, 6'h04, 6'h09},
        '{6'h04, 6'h05, 6'h09}, '{6'h03, 6'h04, 6'h08},
        '{6'h05, 6'h06, 6'h0A}};
    localparam logic [LEN_W-1:0] F1_LEN [0:4][0:2] = '{
        '{3'h2, 3'h2, 3'h3}, '{3'h2, 3'h2, 3'h3}, '{3'h2, 3'h2, 3'h3},
        '{3'h3, 3'h3, 3'h4}, '{3'h3, 3'h3, 3'h4}};

    // Single-operand tables: [mode] register, indirect, immediate, memory
    localparam logic [1:0] MODE_REG = 2'h0;
    localparam logic [1:0] MODE_IND = 2'h1;
    localparam logic [1:0] MODE_IMM = 2'h2;
    localparam logic [1:0] MODE_MEM = 2'h3;
    localparam logic [CYC_W-1:0] ROT_CYC_BW [0:3] = '{6'h00, 6'h04, 6'h00,
        6'h05};
    localparam logic [CYC_W-1:0] ROT_CYC_A [0:3] = '{6'h00, 6'h06, 6'h00,
        6'h07};
    localparam logic [LEN_W-1:0] ROT_LEN [0:3] = '{3'h2, 3'h2, 3'h0, 3'h3};
    localparam logic [CYC_W-1:0] PUSH_CYC_BW [0:3] = '{6'h04, 6'h04, 6'h04,
        6'h05};
    localparam logic [CYC_W-1:0] PUSH_CYC_A [0:3] = '{6'h05, 6'h06, 6'h06,
        6'h07};
    localparam logic [LEN_W-1:0] PUSH_LEN [0:3] = '{3'h2, 3'h2, 3'h3, 3'h3};
    localparam logic [CYC_W-1:0] POP_CYC_BW [0:1] = '{6'h03, 6'h05};
    localparam logic [CYC_W-1:0] POP_CYC_A [0:1] = '{6'h04, 6'h07};
    localparam logic [LEN_W-1:0] POP_LEN [0:1] = '{3'h2, 3'h3};

    typedef enum logic [2:0] {
        CLS_LEGACY, CLS_ADDRESS, CLS_MULTI_ROT, CLS_MULTI_PP,
        CLS_CALL_FAR, CLS_RETURN_FROM_INTERRUPT, CLS_FMT1_EXT, CLS_FMT2_EXT
    } xid_class_t;

    typedef struct packed {
        logic [15:0] op_word;
        logic [15:0] ext_word;
        logic ext_valid;
        logic [3:0] rpt_reg_m1;
        logic [PC_W-1:0] pc;
    } xid_req_t;

    typedef struct packed {
        xid_class_t cls;
        logic illegal;
        logic [LEN_W-1:0] len;
        logic [CYC_W-1:0] cycles;
    } xid_res_t;
endpackage

// ===== rtl/xid_ext_timing.sv
/*
 * Cycle and length lookup for instructions that follow an extension word:
 * extended double-operand and extended single-operand forms.
 * Assumes: the caller has already seen a valid extension word; purely
 * combinational, registered by the decoder that instantiates it.
 */
`timescale 1ns/1ns
module xid_ext_timing (
    input xid_pkg::xid_req_t req,
    output xid_pkg::xid_res_t res
);
    import xid_pkg::*;

    logic [15:0] op;
    logic [15:0] ext;
    logic wide;
    logic [4:0] rpt_n;
    logic [2:0] src;
    logic [1:0] dst;
    logic [1:0] mode;
    logic [3:0] opc;
    logic is_pop;
    logic bad;
    logic [CYC_W-1:0] cyc;
    logic [LEN_W-1:0] len;
    xid_class_t cls;

    always_comb begin
        op = req.op_word;
        ext = req.ext_word;
        opc = op[15:12];
        wide = ~ext[6] & op[6];
        rpt_n = ext[7] ? {1'b0, req.rpt_reg_m1} + 5'h01
                       : {1'b0, ext[3:0]} + 5'h01;
        // Constant-generator sources cost no memory access
        case (op[5:4])
            2'b00: src = SRC_REG;
            2'b01: src = (op[11:8] == CG_REG) ? SRC_REG : SRC_MEM;
            2'b10: src = (op[11:8] == SR_REG || op[11:8] == CG_REG)
                         ? SRC_REG : SRC_IND;
            default: begin
                if (op[11:8] == PC_REG) begin
                    src = SRC_IMM;
                end else if (op[11:8] == SR_REG || op[11:8] == CG_REG) begin
                    src = SRC_REG;
                end else begin
                    src = SRC_AUTO;
                end
            end
        endcase
        dst = op[7] ? DST_MEM : ((op[3:0] == PC_REG) ? DST_PC : DST_REG);
        case (op[5:4])
            2'b00: mode = MODE_REG;
            2'b01: mode = MODE_MEM;
            2'b10: mode = MODE_IND;
            default: mode = (op[3:0] == PC_REG) ? MODE_IMM : MODE_IND;
        endcase
        is_pop = (opc == OPC_TRANSFER) && (op[5:4] == 2'b11)
                 && (op[11:8] == SP_REG);
        cyc = '0;
        len = '0;
        bad = 1'b0;
        cls = CLS_FMT1_EXT;
        if (op[15:14] != 2'b00) begin
            if (is_pop) begin
                cyc = wide ? POP_CYC_A[dst == DST_MEM]
                           : POP_CYC_BW[dst == DST_MEM];
                len = POP_LEN[dst == DST_MEM];
            end else begin
                cyc = wide ? F1_CYC_A[src][dst] : F1_CYC_BW[src][dst];
                len = F1_LEN[src][dst];
                if (dst == DST_MEM && (opc == OPC_TRANSFER
                        || opc == OPC_TEST || opc == OPC_COMPARE)) begin
                    cyc = cyc - (wide ? CYC_TWO : CYC_ONE);
                end
                if (dst == DST_PC && (src == SRC_IMM || src == SRC_MEM)
                        && (opc == OPC_TRANSFER || opc == OPC_SUM
                        || opc == OPC_MINUS)) begin
                    cyc = cyc - CYC_ONE;
                end
                if (src == SRC_REG && dst == DST_REG) begin
                    cyc = {1'b0, rpt_n} + CYC_ONE;
                end
            end
        end else if (op[15:10] == FMT2_PREFIX) begin
            cls = CLS_FMT2_EXT;
            if (op[9:7] <= F2_ROT_LAST) begin
                if (mode == MODE_IMM) begin
                    bad = 1'b1;
                end else if (mode == MODE_REG) begin
                    cyc = {1'b0, rpt_n} + CYC_ONE;
                end else begin
                    cyc = wide ? ROT_CYC_A[mode] : ROT_CYC_BW[mode];
                end
                len = ROT_LEN[mode];
            end else if (op[9:7] == F2_PUSH) begin
                cyc = wide ? PUSH_CYC_A[mode] : PUSH_CYC_BW[mode];
                len = PUSH_LEN[mode];
                if (op[5:4] == 2'b01 && op[3:0] == SP_REG) begin
                    cyc = cyc + CYC_ONE;
                end
            end else begin
                bad = 1'b1;
            end
        end else begin
            bad = 1'b1;
        end
        res.cls = cls;
        res.illegal = bad;
        res.len = bad ? '0 : len;
        res.cycles = bad ? '0 : cyc;
    end
endmodule

// ===== rtl/xid_decoder.sv
/*
 * Extended instruction decoder with execution-cycle and length timing.
 * Takes one instruction word (plus an optional preceding extension word),
 * classifies it, flags reserved encodings, works out its length and the
 * program counter past all its words, and then holds off the next request
 * for as many clock cycles as the instruction takes.
 * Assumes: requests are synchronous to core_clk; the core supplies the
 * register-held repeat count when the extension word asks for one.
 */
`timescale 1ns/1ns
// How it works
// - Cycle counts are clock periods, by format
// - Multi-rotates register only, one word, n cycles
// - Multi push/pop: 2+n, or 2+2n wide
// - Far call cycles and words per mode
// - Extended push cycles per mode and width
// - Extended pop: register or memory destinations only
// - Extended rotates: 1+n register, immediate invalid, table otherwise
// - Stack-pointer index adds one cycle
// - Register source double-operand timing
// - Indirect or autoincrement source timing
// - Immediate source timing
// - Indexed, symbolic or absolute source timing
// - Repeated register-register takes n+1 cycles
// - Transfer, test, compare to memory faster
// - Transfer, sum, minus into counter faster
// - Address instruction cycles and lengths
// - Top opcode nibbles select instruction group
// - Address word field layout
// - Address identifier meanings
// - Multi-rotate word field layout
// - Reserved far-call encodings are invalid
// - Multi push/pop word field layout
module xid_decoder (
    input logic core_clk,
    input logic reset_n,
    input logic clk_en,
    input logic req_valid,
    input xid_pkg::xid_req_t req,
    output logic req_ready,
    output logic res_valid,
    output xid_pkg::xid_res_t res,
    output logic [xid_pkg::PC_W-1:0] pc_next,
    output logic exc_pulse,
    output logic exec_done
);
    import xid_pkg::*;

    typedef enum logic [0:0] {ST_IDLE, ST_EXEC} xid_state_t;

    typedef struct packed {
        xid_state_t st;
        logic [CYC_W-1:0] cnt;
        logic ready;
        logic res_valid;
        xid_res_t res;
        logic [PC_W-1:0] pc_next;
        logic exc;
        logic done;
        logic [15:0] op;
        logic ext;
        logic [PC_W-1:0] pc_req;
        logic [CYC_W-1:0] elapsed;
    } xid_regs_t;

    xid_regs_t s_q;
    xid_regs_t s_d;
    xid_res_t ext_res;
    xid_res_t dec;

    xid_ext_timing u_ext (
        .req(req),
        .res(ext_res)
    );

    function automatic xid_res_t decode(xid_req_t r, xid_res_t er);
        xid_res_t d;
        logic [3:0] id;
        logic [CYC_W-1:0] n;
        d.cls = CLS_LEGACY;
        d.illegal = 1'b0;
        d.len = 3'h1;
        d.cycles = '0;
        id = r.op_word[7:4];
        if (r.ext_valid) begin
            d = er;
        end else if (r.op_word[15:12] == GRP_ADDR) begin
            if (id == AID_ROT20 || id == AID_ROT16) begin
                d.cls = CLS_MULTI_ROT;
                d.cycles = {4'h0, r.op_word[11:10]} + CYC_ONE;
            end else begin
                d.cls = CLS_ADDRESS;
                d.cycles = ADDR_CYC[id];
                d.len = ADDR_LEN[id];
                if (r.op_word[3:0] == PC_REG && (id == AID_IMM_MOVE
                        || id[3:2] == AID_REGREG)) begin
                    d.cycles = d.cycles + CYC_ONE;
                end
            end
        end else if (r.op_word[15:8] == CALL_PREFIX) begin
            if (r.op_word == RETURN_FROM_INTERRUPT_WORD) begin
                d.cls = CLS_RETURN_FROM_INTERRUPT;
                d.cycles = RETURN_FROM_INTERRUPT_CYC;
            end else if (id == CID_RSVD || id[3:2] == 2'b11
                    || id < CID_FIRST) begin
                d.illegal = 1'b1;
                d.len = '0;
            end else begin
                d.cls = CLS_CALL_FAR;
                d.cycles = CALL_CYC[id];
                d.len = CALL_LEN[id];
                if (id == CID_IDX && r.op_word[3:0] == SP_REG) begin
                    d.cycles = d.cycles + CYC_ONE;
                end
            end
        end else if (r.op_word[15:10] == MPP_PREFIX) begin
            d.cls = CLS_MULTI_PP;
            n = {2'h0, id} + CYC_ONE;
            d.cycles = r.op_word[8] ? MPP_BASE + n
                                    : MPP_BASE + {n[CYC_W-2:0], 1'b0};
        end else if (r.op_word[15:11] == EXT_PREFIX) begin
            d.illegal = 1'b1;
            d.len = '0;
        end
        return d;
    endfunction

    always_comb begin
        dec = decode(req, ext_res);
        s_d = s_q;
        s_d.res_valid = 1'b0;
        s_d.exc = 1'b0;
        s_d.done = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                if (req_valid) begin
                    s_d.res_valid = 1'b1;
                    s_d.res = dec;
                    s_d.op = req.op_word;
                    s_d.ext = req.ext_valid;
                    s_d.pc_req = req.pc;
                    s_d.elapsed = CYC_ONE;
                    s_d.pc_next = req.pc + {{(PC_W-LEN_W-1){1'b0}},
                                            dec.len, 1'b0};
                    if (dec.illegal) begin
                        s_d.exc = 1'b1;
                    end else if (dec.cycles <= CYC_ONE) begin
                        s_d.done = 1'b1;
                    end else begin
                        s_d.st = ST_EXEC;
                        s_d.cnt = dec.cycles - CYC_ONE;
                        s_d.ready = 1'b0;
                    end
                end
            end
            ST_EXEC: begin
                s_d.elapsed = s_q.elapsed + CYC_ONE;
                s_d.cnt = s_q.cnt - CYC_ONE;
                if (s_q.cnt == CYC_ONE) begin
                    s_d.st = ST_IDLE;
                    s_d.ready = 1'b1;
                    s_d.done = 1'b1;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
                s_d.ready = 1'b1;
            end
        endcase
    end

    // Whole state freezes while the clock enable is low
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.ready <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign req_ready = s_q.ready;
    assign res_valid = s_q.res_valid;
    assign res = s_q.res;
    assign pc_next = s_q.pc_next;
    assign exc_pulse = s_q.exc;
    assign exec_done = s_q.done;

    a_done_timing: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.done |-> (s_q.elapsed == s_q.res.cycles || s_q.res.cycles == '0))
        else $error("completion not at decoded cycle count");

    a_multi_rot_cyc: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid && !s_q.ext && s_q.op[15:12] == GRP_ADDR
        && s_q.op[7:5] == 3'h2
        |-> s_q.res.cycles == {4'h0, s_q.op[11:10]} + 6'h01
            && s_q.res.len == 3'h1)
        else $error("multi-rotate timing wrong");

    a_push_pop_cyc: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid && !s_q.ext && s_q.op[15:10] == MPP_PREFIX
        |-> s_q.res.cycles == (s_q.op[8]
            ? 6'h03 + {2'h0, s_q.op[7:4]}
            : 6'h04 + {1'b0, s_q.op[7:4], 1'b0}))
        else $error("multi push/pop timing wrong");

    a_reserved_call: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid && !s_q.ext && s_q.op[15:8] == CALL_PREFIX
        && (s_q.op[7:4] == 4'hA || s_q.op[7:6] == 2'b11)
        |-> s_q.res.illegal && s_q.exc)
        else $error("reserved call encoding accepted");

    a_exc_no_exec: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.exc |-> s_q.ready && !s_q.done && s_q.st == ST_IDLE
            && s_q.res.illegal && s_q.res.cycles == '0)
        else $error("reserved encoding went into execution");

    a_pc_advance: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid |-> s_q.pc_next
            == s_q.pc_req + {{(PC_W-4){1'b0}}, s_q.res.len, 1'b0})
        else $error("program counter not advanced by length");

    a_addr_regreg: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid && !s_q.ext && s_q.op[15:12] == GRP_ADDR
        && s_q.op[7:6] == 2'b11
        |-> s_q.res.len == 3'h1 && s_q.res.cycles
            == ((s_q.op[3:0] == PC_REG) ? 6'h02 : 6'h01))
        else $error("register address instruction timing wrong");

    a_return_from_interrupt_decode: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid && !s_q.ext && s_q.op == RETURN_FROM_INTERRUPT_WORD
        |-> s_q.res.cls == CLS_RETURN_FROM_INTERRUPT && s_q.res.len == 3'h1
            && !s_q.res.illegal)
        else $error("interrupt return misdecoded");

    a_busy_blocks: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !s_q.ready && clk_en |=> !s_q.res_valid && !s_q.exc
            && (s_q.st == ST_EXEC || s_q.done))
        else $error("accepted a request while executing");

    a_done_ready: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.done |-> s_q.ready && s_q.st == ST_IDLE)
        else $error("completion while still busy");

    a_call_reg_cyc: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid && !s_q.ext && s_q.op[15:8] == CALL_PREFIX
        && s_q.op[7:4] == 4'h4
        |-> s_q.res.cycles == 6'h04 && s_q.res.len == 3'h1)
        else $error("far call register timing wrong");

    a_call_index_sp: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid && !s_q.ext && s_q.op[15:8] == CALL_PREFIX
        && s_q.op[7:4] == CID_IDX
        |-> s_q.res.len == 3'h2 && s_q.res.cycles
            == ((s_q.op[3:0] == SP_REG) ? 6'h07 : 6'h06))
        else $error("far call indexed timing wrong");

    a_call_abs_cyc: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid && !s_q.ext && s_q.op[15:8] == CALL_PREFIX
        && s_q.op[7:5] == 3'h4
        |-> s_q.res.cycles == 6'h06 && s_q.res.len == 3'h2)
        else $error("far call absolute timing wrong");

    a_jump_legacy: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid && !s_q.ext && s_q.op[15:13] == 3'h1
        |-> s_q.res.cls == CLS_LEGACY && !s_q.res.illegal
            && s_q.res.len == 3'h1 && s_q.res.cycles == '0)
        else $error("jump not passed through as legacy");

    a_addr_imm_cyc: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid && !s_q.ext && s_q.op[15:12] == GRP_ADDR
        && s_q.op[7:6] == 2'b10
        |-> s_q.res.len == 3'h2 && s_q.res.cycles
            == ((s_q.op[5:4] == 2'b00 && s_q.op[3:0] != PC_REG)
            ? 6'h02 : 6'h03))
        else $error("immediate address instruction timing wrong");

    a_mpp_class: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_q.res_valid && !s_q.ext && s_q.op[15:10] == MPP_PREFIX
        |-> s_q.res.cls == CLS_MULTI_PP && s_q.res.len == 3'h1
            && !s_q.res.illegal)
        else $error("multi push/pop misdecoded");
endmodule

// ===== bench/xid_prog_mem.sv
/*
 * Program memory partner: holds instruction words and shows the word at
 * the fetch address and the word after it.
 * Assumes: the bench loads words by hierarchical write between requests;
 * only the low six word-address bits are decoded.
 */
`timescale 1ns/1ns
module xid_prog_mem (
    input wire logic [19:0] fetch_addr,
    output logic [15:0] word_lo,
    output logic [15:0] word_hi
);
    logic [15:0] mem [0:63];

    // Unloaded words carry a varying pattern, never a copy of a real word
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 16'(i) ^ 16'hA5A5;
        end
    end

    // Operand words follow the first word at the next even address
    assign word_lo = mem[fetch_addr[6:1]];
    assign word_hi = mem[fetch_addr[6:1] + 6'h01];
endmodule

// ===== bench/tb_top.sv
/*
 * Self-checking bench for the extended decoder: one task per scenario,
 * each request built from words held in the program memory partner.
 * Assumes: the decoder contract of one request at a time, results registered
 * on the taking edge, and a 100 ns core clock.
 */
`timescale 1ns/1ns
module tb_top;
    import xid_pkg::*;
    localparam logic [19:0] BASE_PC = 20'h1F000;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    xid_req_t req = '0;
    logic req_ready, res_valid, exc_pulse, exec_done;
    xid_res_t res;
    logic [PC_W-1:0] pc_next;
    logic [15:0] word_lo, word_hi;
    int mismatches = 0;
    int num_checks = 0;
    int stall_cyc = 0;
    logic follow_bad = 1'b0;

    always #50 core_clk = ~core_clk;

    xid_decoder u_xid_decoder (.core_clk(core_clk), .reset_n(reset_n),
        .clk_en(clk_en), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .res_valid(res_valid), .res(res),
        .pc_next(pc_next), .exc_pulse(exc_pulse), .exec_done(exec_done));
    xid_prog_mem u_xid_prog_mem (.fetch_addr(BASE_PC), .word_lo(word_lo),
        .word_hi(word_hi));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // An ext of zero means the instruction stands alone
    task automatic run(input logic [15:0] ext, input logic [15:0] op,
            input xid_class_t ecls, input logic [2:0] elen,
            input logic [5:0] ecyc);
        int k;
        logic ill;
        logic has_ext;
        ill = (elen == 3'h0);
        u_xid_prog_mem.mem[0] = (ext != 16'h0) ? ext : op;
        u_xid_prog_mem.mem[1] = op;
        @(posedge core_clk);
        has_ext = (word_lo[15:11] == 5'h03);
        req_valid <= 1'b1;
        req <= '{op_word: (has_ext ? word_hi : word_lo), ext_word: word_lo,
            ext_valid: has_ext, rpt_reg_m1: 4'h2, pc: BASE_PC};
        k = 0;
        @(negedge core_clk);
        while (req_ready !== 1'b1 && k < 50) begin
            @(negedge core_clk);
            k++;
        end
        if (k >= 50) begin
            mismatches++;
            wrap_up;
        end
        @(posedge core_clk);
        req_valid <= follow_bad;
        req.op_word <= 16'h13A0;
        req.ext_valid <= 1'b0;
        clk_en <= (stall_cyc == 0);
        @(negedge core_clk);
        check(res_valid, 1'b1);
        check(exc_pulse, ill);
        check(res.illegal, ill);
        check(res.len, elen);
        check(res.cycles, ecyc);
        check(pc_next, BASE_PC + 20'(2 * elen));
        if (!ill) check(res.cls, ecls);
        check(req_ready, ecyc < 6'h02);
        check(exec_done, !ill && ecyc < 6'h02);
        for (k = 0; k < stall_cyc; k++) begin
            @(posedge core_clk);
            if (k == stall_cyc - 1) clk_en <= 1'b1;
        end
        if (stall_cyc > 0) begin
            @(negedge core_clk);
            check(res_valid, 1'b1);
        end
        k = 1;
        while (!ill && exec_done !== 1'b1 && k < 70) begin
            @(negedge core_clk);
            k++;
            check(res_valid | exc_pulse, 1'b0);
        end
        if (k >= 70) begin
            mismatches++;
            wrap_up;
        end
        check(k, (ecyc > 6'h01) ? ecyc : 6'h01);
        check(req_ready, 1'b1);
        if (follow_bad) begin
            @(posedge core_clk);
            req_valid <= 1'b0;
            @(negedge core_clk);
            check(exc_pulse, 1'b1);
        end
    endtask

    task automatic scn_multi;
        for (int i = 0; i < 4; i++) begin
            run(16'h0, 16'h1424 | 16'(i << 8), CLS_MULTI_PP, 3'h1,
                i[0] ? 6'h05 : 6'h08);
            run(16'h0, 16'h0C55 | 16'(i << 8), CLS_MULTI_ROT, 3'h1,
                6'h04);
        end
        run(16'h0, 16'h0045, CLS_MULTI_ROT, 3'h1, 6'h01);
    endtask

    task automatic scn_address;
        run(16'h0, 16'h05C6, CLS_ADDRESS, 3'h1, 6'h01);
        run(16'h0, 16'h05C0, CLS_ADDRESS, 3'h1, 6'h02);
        run(16'h0, 16'h0086, CLS_ADDRESS, 3'h2, 6'h02);
        run(16'h0, 16'h00B6, CLS_ADDRESS, 3'h2, 6'h03);
        run(16'h0, 16'h0516, CLS_ADDRESS, 3'h1, 6'h03);
        run(16'h0, 16'h0576, CLS_ADDRESS, 3'h2, 6'h04);
        run(16'h0, 16'h0526, CLS_ADDRESS, 3'h2, 6'h04);
        run(16'h0, 16'h05A6, CLS_ADDRESS, 3'h2, 6'h03);
    endtask

    task automatic scn_call;
        run(16'h0, 16'h1300, CLS_RETURN_FROM_INTERRUPT, 3'h1, 6'h05);
        run(16'h0, 16'h1345, CLS_CALL_FAR, 3'h1, 6'h04);
        run(16'h0, 16'h1355, CLS_CALL_FAR, 3'h2, 6'h06);
        run(16'h0, 16'h1351, CLS_CALL_FAR, 3'h2, 6'h07);
        run(16'h0, 16'h1375, CLS_CALL_FAR, 3'h1, 6'h05);
        run(16'h0, 16'h1365, CLS_CALL_FAR, 3'h1, 6'h05);
        run(16'h0, 16'h1390, CLS_CALL_FAR, 3'h2, 6'h06);
        run(16'h0, 16'h13B0, CLS_CALL_FAR, 3'h2, 6'h04);
        run(16'h0, 16'h13A0, CLS_CALL_FAR, 3'h0, 6'h00);
        run(16'h0, 16'h13C5, CLS_CALL_FAR, 3'h0, 6'h00);
        run(16'h0, 16'h3C00, CLS_LEGACY, 3'h1, 6'h00);
    endtask

    task automatic scn_ext;
        run(16'h18C0, 16'h4508, CLS_FMT1_EXT, 3'h2, 6'h04);
        run(16'h1840, 16'h5586, CLS_FMT1_EXT, 3'h3, 6'h05);
        run(16'h1800, 16'h55C6, CLS_FMT1_EXT, 3'h3, 6'h07);
        run(16'h1800, 16'h45C6, CLS_FMT1_EXT, 3'h3, 6'h05);
        run(16'h1840, 16'h5030, CLS_FMT1_EXT, 3'h3, 6'h03);
        run(16'h1840, 16'hA030, CLS_FMT1_EXT, 3'h3, 6'h04);
        run(16'h1840, 16'h5518, CLS_FMT1_EXT, 3'h3, 6'h04);
        run(16'h1840, 16'h5526, CLS_FMT1_EXT, 3'h2, 6'h03);
        run(16'h1840, 16'h41B5, CLS_FMT1_EXT, 3'h3, 6'h05);
        run(16'h1841, 16'h1005, CLS_FMT2_EXT, 3'h2, 6'h03);
        run(16'h1800, 16'h1055, CLS_FMT2_EXT, 3'h3, 6'h07);
        run(16'h1840, 16'h1211, CLS_FMT2_EXT, 3'h3, 6'h06);
        run(16'h1800, 16'h1245, CLS_FMT2_EXT, 3'h2, 6'h05);
        run(16'h1840, 16'h1030, CLS_FMT2_EXT, 3'h0, 6'h00);
    endtask

    // Frozen clock, then a reserved word waiting while the decoder is busy
    task automatic scn_busy;
        stall_cyc = 2;
        follow_bad = 1'b1;
        run(16'h0, 16'h1524, CLS_MULTI_PP, 3'h1, 6'h05);
        stall_cyc = 0;
        follow_bad = 1'b0;
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        scn_multi();
        scn_address();
        scn_call();
        scn_ext();
        scn_busy();
        wrap_up();
    end
endmodule
